// [rgcd_cmd_decoder.sv]
`timescale 1ns/100ps
// How it works
// - start gap 10..50 field clocks, later gaps 8..30, others flagged
// - interval 16..31 clocks is a zero, 48..63 clocks is a one
// - the first two bits received are the opcode
// - opcodes 10 and 11 do write or direct access on page 0 or 1
// - opcode 00 restarts the whole power-on sequence and reloads configuration
// - opcode 01 is test write, ignored once master key equals 6
// - master key change refused while block 0 lock or otp set
// - standard write: opcode, lock, 32 data, 3 address bits, 38 total
// - password mode puts 32 password bits right after the opcode
// - invalid command returns to regular read on previously chosen page
// - password bits compared with block 7, first bit first
// - password mismatch means no programming, regular read after the frame
// - answer-on-request: no modulation until a valid wake-up command
// - wake-up is opcode 10 plus the valid password
// - woken tag stays active until reset or different password
// - non-matching password deactivates a woken tag in answer-on-request mode
// - password without answer-on-request: modulate, need password to write
// - fixed delay between frame end and programming start
// - programming lasts 5.6 ms and ends with a verify result
// - after good programming, repeat the block just programmed
// - interval outside both bit windows is a writing error
// - no gap for 64 clocks ends the frame and bits are judged
// - valid counts are 70, 38, 34, 6 and 2 bits
// - direct access: page opcode, zero bit, 3-bit block, then block read
module rgcd_cmd_decoder #(
  parameter int PROG_CYCLES = rgcd_pkg::PROG_FC
) (
  // clock and reset
  input  wire logic               SYS_CLK_IN,
  input  wire logic               RST_N_IN,
  // wishbone slave
  input  wire logic               WB_CYC_IN,
  input  wire logic               WB_STB_IN,
  input  wire logic               WB_WE_IN,
  input  wire logic [7:0]         WB_ADR_IN,
  input  wire logic [3:0]         WB_SEL_IN,
  input  wire logic [31:0]        WB_DAT_IN,
  output logic      [31:0]        WB_DAT_OUT,
  output logic                    WB_ACK_OUT,
  // field gap detector pin
  input  wire logic               GAP_IN,
  // memory controller side
  input  wire logic               PROG_OK_IN,
  output rgcd_pkg::rgcd_prog_type PROG_OUT,
  output logic                    TEST_STB_OUT,
  // read path control
  output logic                    MOD_EN_OUT,
  output rgcd_pkg::rgcd_rd_type   RD_OUT,
  // events
  output logic                    RESET_CMD_OUT,
  output logic                    WRITE_ERR_OUT
);
  import rgcd_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic           gap_s1_reg;
  logic           gap_s2_reg;
  rgcd_state_type state_reg;
  logic [17:0]    tmr_reg;
  rgcd_evt_type   evt;
  logic           arm;
  logic [69:0]    sh_reg;
  logic [6:0]     cnt_reg;
  logic           ferr_reg;
  logic [31:0]    cfg_reg;
  logic [31:0]    pwd_reg;
  rgcd_mode_type  mode_reg;
  logic           woken_reg;
  logic           rej_reg;
  rgcd_rd_type    rd_reg;
  rgcd_prog_type  prog_reg;
  logic           mod_reg;
  logic           test_reg;
  logic           rstc_reg;
  logic           werr_reg;
  logic           ack_reg;
  logic [31:0]    dat_reg;
  logic [31:0]    rd_mux;
  logic           wb_req;
  logic           wb_wr;
  // decode results
  logic [1:0]     op;
  logic [31:0]    pw;
  logic           pw_chk;
  logic           pw_bad;
  logic           dec_rst;
  logic           dec_pg;
  logic           dec_wr;
  logic           dec_da;
  logic           dec_wake;
  logic           dec_test;
  logic           key_bad;
  logic           test_ign;
  logic           cmd_ok;
  logic           frame_end;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    merge = r;
  endfunction

  // ----------------------------------------
  // gap input synchroniser
  // ----------------------------------------
  // the detector is analog and asynchronous to logic, so two flops
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      gap_s1_reg <= 1'b0;
      gap_s2_reg <= 1'b0;
    end else begin
      gap_s1_reg <= GAP_IN;
      gap_s2_reg <= gap_s1_reg;
    end
  end

  // gaps only count while reading or receiving, not while programming
  assign arm = (state_reg == ST_READ) || (state_reg == ST_RX);

  rgcd_gap_timer u_gap (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RST_N_IN),
    .arm_in   (arm),
    .gap_in   (gap_s2_reg),
    .evt_out  (evt)
  );

  // ----------------------------------------
  // bit collection
  // ----------------------------------------
  // first received bit ends up highest; count saturates past 70
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      sh_reg   <= '0;
      cnt_reg  <= 7'h00;
      ferr_reg <= 1'b0;
    end else if (evt.start) begin
      sh_reg   <= '0;
      cnt_reg  <= 7'h00;
      ferr_reg <= 1'b0;
    end else begin
      if (evt.bit_ok) begin
        sh_reg <= {sh_reg[68:0], evt.bit_val};
        if (cnt_reg != NB_MAX) cnt_reg <= cnt_reg + 7'h01;
      end
      if (evt.err) ferr_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // fields are found by total length, so the opcode sits at the top
  always_comb begin
    op       = 2'h0;
    pw       = 32'h0000_0000;
    pw_chk   = 1'b0;
    dec_rst  = 1'b0;
    dec_pg   = 1'b0;
    dec_wr   = 1'b0;
    dec_da   = 1'b0;
    dec_wake = 1'b0;
    dec_test = 1'b0;
    case (cnt_reg)
      NB_OP: begin
        op      = sh_reg[1:0];
        dec_rst = (op == OP_RST);
        dec_pg  = op[1];
      end
      NB_DA: begin
        op     = sh_reg[5:4];
        dec_da = !mode_reg.password_mode_bit && op[1] && !sh_reg[3];
      end
      NB_WAKE: begin
        op       = sh_reg[33:32];
        pw       = sh_reg[31:0];
        pw_chk   = mode_reg.password_mode_bit && (op == OP_PG0);
        dec_wake = pw_chk;
      end
      NB_STD: begin
        op = sh_reg[37:36];
        if (mode_reg.password_mode_bit) begin
          pw     = sh_reg[35:4];
          pw_chk = op[1];
          dec_da = op[1] && !sh_reg[3];
        end else begin
          dec_wr   = op[1];
          dec_test = (op == OP_TEST);
        end
      end
      NB_PWR: begin
        op     = sh_reg[69:68];
        pw     = sh_reg[67:36];
        pw_chk = mode_reg.password_mode_bit && op[1];
        dec_wr = pw_chk;
      end
      default: begin
        op = 2'h0;
      end
    endcase
    pw_bad   = pw_chk && (pw != pwd_reg);
    key_bad  = dec_wr && (op == OP_PG0) && (sh_reg[2:0] == 3'h0)
               && (sh_reg[34:31] != mode_reg.key)
               && (mode_reg.lock || mode_reg.otp);
    test_ign = dec_test && (mode_reg.key == KEY_LOCKED);
    cmd_ok   = !ferr_reg && !pw_bad && !key_bad && !test_ign
               && (dec_rst || dec_pg || dec_wr || dec_da || dec_wake || dec_test);
  end

  assign frame_end = (state_reg == ST_RX) && evt.eot;

  // ----------------------------------------
  // sequencer and shared timer
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      state_reg <= ST_INIT;
      tmr_reg   <= 18'h00000;
    end else begin
      case (state_reg)
        ST_INIT: begin
          if (gap_s2_reg) begin
            tmr_reg <= 18'h00000;                        // gap restarts the load
          end else if (tmr_reg == INIT_FC - 18'h00001) begin
            tmr_reg   <= 18'h00000;
            state_reg <= ST_READ;
          end else begin
            tmr_reg <= tmr_reg + 18'h00001;
          end
        end
        ST_READ: begin
          if (evt.start) state_reg <= ST_RX;
        end
        ST_RX: begin
          if (frame_end) begin
            if (cmd_ok && dec_rst) begin
              state_reg <= ST_INIT;
            end else if (cmd_ok && dec_wr) begin
              state_reg <= ST_DELAY;
            end else begin
              state_reg <= ST_READ;
            end
          end
        end
        ST_DELAY: begin
          if (tmr_reg == PROG_DELAY_FC - 18'h00001) begin
            tmr_reg   <= 18'h00000;
            state_reg <= ST_PROG;
          end else begin
            tmr_reg <= tmr_reg + 18'h00001;
          end
        end
        ST_PROG: begin
          if (tmr_reg == 18'(PROG_CYCLES - 1)) begin
            tmr_reg   <= 18'h00000;
            state_reg <= ST_READ;
          end else begin
            tmr_reg <= tmr_reg + 18'h00001;
          end
        end
        default: begin
          state_reg <= ST_INIT;
        end
      endcase
    end
  end

  // ----------------------------------------
  // configuration latch
  // ----------------------------------------
  // held static between loads so a write to the image cannot change mode mid-frame
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      mode_reg <= '0;
    end else if (state_reg == ST_INIT && !gap_s2_reg
                 && tmr_reg == INIT_FC - 18'h00001) begin
      mode_reg.password_mode_bit    <= cfg_reg[CFG_PWD_BIT];
      mode_reg.answer_on_request_bit    <= cfg_reg[CFG_AOR_BIT];
      mode_reg.otp    <= cfg_reg[CFG_OTP_BIT];
      mode_reg.lock   <= cfg_reg[CFG_LOCK_BIT];
      mode_reg.key    <= cfg_reg[CFG_KEY_LSB +: 4];
      mode_reg.last_block_limit <= cfg_reg[CFG_LAST_BLOCK_LIMIT_LSB +: 3];
    end
  end

  // ----------------------------------------
  // wake state and read selection
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN || state_reg == ST_INIT) begin
      woken_reg <= 1'b0;
    end else if (frame_end) begin
      if (cmd_ok && dec_wake) begin
        woken_reg <= 1'b1;
      end else if (pw_bad && mode_reg.answer_on_request_bit) begin
        woken_reg <= 1'b0;
      end
    end
  end

  // page only moves on an accepted page opcode
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      rd_reg  <= '0;
      rej_reg <= 1'b0;
    end else if (frame_end) begin
      rej_reg          <= !cmd_ok;
      rd_reg.block_mode <= 1'b0;
      if (cmd_ok && (dec_pg || dec_da || dec_wr)) begin
        rd_reg.page <= op[0];
      end
      if (cmd_ok && dec_da) begin
        rd_reg.block_mode <= 1'b1;
        rd_reg.block      <= sh_reg[2:0];
      end
    end else if (state_reg == ST_PROG && tmr_reg == 18'(PROG_CYCLES - 1)) begin
      rd_reg.block_mode <= PROG_OK_IN;
      rd_reg.block      <= prog_reg.addr;
      rej_reg           <= !PROG_OK_IN;
    end
  end

  // ----------------------------------------
  // programming and test outputs
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      prog_reg <= '0;
      test_reg <= 1'b0;
    end else begin
      test_reg    <= frame_end && cmd_ok && dec_test;
      prog_reg.en <= (state_reg == ST_PROG);
      if (frame_end && cmd_ok && (dec_wr || dec_test)) begin
        prog_reg.page <= op[0];
        prog_reg.lock <= sh_reg[35];
        prog_reg.data <= sh_reg[34:3];
        prog_reg.addr <= sh_reg[2:0];
      end
    end
  end

  // ----------------------------------------
  // modulation and event pulses
  // ----------------------------------------
  // no modulation while loading, receiving or programming
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      mod_reg  <= 1'b0;
      rstc_reg <= 1'b0;
      werr_reg <= 1'b0;
    end else begin
      mod_reg  <= (state_reg == ST_READ) && (!mode_reg.answer_on_request_bit || woken_reg);
      rstc_reg <= frame_end && cmd_ok && dec_rst;
      werr_reg <= (state_reg == ST_RX) && evt.err;
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  // one wait state; write lands on the edge where ack is sampled
  assign wb_req = WB_CYC_IN && WB_STB_IN;
  assign wb_wr  = wb_req && WB_WE_IN && ack_reg;

  // read mux, unmapped addresses read zero
  always_comb begin
    case (WB_ADR_IN)
      REG_CFG:    rd_mux = cfg_reg;
      REG_PWD:    rd_mux = pwd_reg;
      REG_STATUS: rd_mux = 32'({rej_reg, ferr_reg,
                                rd_reg.block, rd_reg.block_mode, rd_reg.page,
                                mod_reg, woken_reg, mode_reg.answer_on_request_bit, mode_reg.password_mode_bit})
                           | (32'(cnt_reg) << STS_CNT_LSB);   // count alone in bits 22:16
      REG_DATA:   rd_mux = prog_reg.data;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req && !ack_reg;
      if (wb_req && !ack_reg) dat_reg <= rd_mux;
    end
  end

  // block 0 image and password block, software owned
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      cfg_reg <= CFG_RST;
      pwd_reg <= PWD_RST;
    end else if (wb_wr) begin
      if (WB_ADR_IN == REG_CFG) cfg_reg <= merge(cfg_reg, WB_DAT_IN, WB_SEL_IN);
      if (WB_ADR_IN == REG_PWD) pwd_reg <= merge(pwd_reg, WB_DAT_IN, WB_SEL_IN);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign WB_ACK_OUT    = ack_reg;
  assign WB_DAT_OUT    = dat_reg;
  assign PROG_OUT      = prog_reg;
  assign TEST_STB_OUT  = test_reg;
  assign MOD_EN_OUT    = mod_reg;
  assign RD_OUT        = rd_reg;
  assign RESET_CMD_OUT = rstc_reg;
  assign WRITE_ERR_OUT = werr_reg;

endmodule

// [rgcd_pkg.sv]
package rgcd_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int          CLK_MHZ       = 25;
  localparam int          PROG_TIME_US  = 5600;               // typical programming time
  localparam int          PROG_FC       = PROG_TIME_US * CLK_MHZ;
  localparam int          TMR_W         = 18;
  localparam logic [17:0] INIT_FC       = 18'h000C0;          // 192 field clocks
  localparam logic [17:0] PROG_DELAY_FC = 18'h00010;          // wait before programming

  // ----------------------------------------
  // gap and interval windows, in field clocks
  // ----------------------------------------
  localparam logic [6:0] SGAP_MIN = 7'h0A;
  localparam logic [6:0] SGAP_MAX = 7'h32;
  localparam logic [6:0] WGAP_MIN = 7'h08;
  localparam logic [6:0] WGAP_MAX = 7'h1E;
  localparam logic [6:0] D0_MIN   = 7'h10;
  localparam logic [6:0] D0_MAX   = 7'h1F;
  localparam logic [6:0] D1_MIN   = 7'h30;
  localparam logic [6:0] D1_MAX   = 7'h3F;
  localparam logic [6:0] EOT_FC   = 7'h40;
  localparam logic [6:0] CNT_SAT  = 7'h7F;

  // ----------------------------------------
  // command lengths and opcodes
  // ----------------------------------------
  localparam logic [6:0] NB_OP   = 7'h02;
  localparam logic [6:0] NB_DA   = 7'h06;
  localparam logic [6:0] NB_WAKE = 7'h22;
  localparam logic [6:0] NB_STD  = 7'h26;
  localparam logic [6:0] NB_PWR  = 7'h46;
  localparam logic [6:0] NB_MAX  = 7'h47;
  localparam logic [1:0] OP_RST  = 2'h0;
  localparam logic [1:0] OP_TEST = 2'h1;
  localparam logic [1:0] OP_PG0  = 2'h2;
  localparam logic [3:0] KEY_LOCKED = 4'h6;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  REG_CFG    = 8'h00;
  localparam logic [7:0]  REG_PWD    = 8'h04;
  localparam logic [7:0]  REG_STATUS = 8'h08;
  localparam logic [7:0]  REG_DATA   = 8'h0C;
  localparam logic [31:0] CFG_RST    = 32'h0000_0000;
  localparam logic [31:0] PWD_RST    = 32'h0000_0000;
  localparam int CFG_LAST_BLOCK_LIMIT_LSB = 0;
  localparam int CFG_AOR_BIT    = 3;
  localparam int CFG_PWD_BIT    = 4;
  localparam int CFG_OTP_BIT    = 5;
  localparam int CFG_LOCK_BIT   = 8;
  localparam int CFG_KEY_LSB    = 28;
  localparam int STS_CNT_LSB    = 16;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {ST_INIT, ST_READ, ST_RX, ST_DELAY, ST_PROG} rgcd_state_type;

  typedef struct packed {
    logic start;
    logic bit_ok;
    logic bit_val;
    logic err;
    logic eot;
  } rgcd_evt_type;

  typedef struct packed {
    logic       block_mode;
    logic       page;
    logic [2:0] block;
  } rgcd_rd_type;

  typedef struct packed {
    logic        en;
    logic        page;
    logic        lock;
    logic [2:0]  addr;
    logic [31:0] data;
  } rgcd_prog_type;

  typedef struct packed {
    logic       password_mode_bit;
    logic       answer_on_request_bit;
    logic       otp;
    logic       lock;
    logic [3:0] key;
    logic [2:0] last_block_limit;
  } rgcd_mode_type;

  // window test used for gap widths and intervals
  function automatic logic in_win(input logic [6:0] v, input logic [6:0] lo,
                                  input logic [6:0] hi);
    in_win = (v >= lo) && (v <= hi);
  endfunction

endpackage

// [rgcd_gap_timer.sv]
`timescale 1ns/100ps
module rgcd_gap_timer (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // synchronised gap level and arming
  input  wire logic              arm_in,
  input  wire logic              gap_in,
  // decoded events, one-cycle pulses
  output rgcd_pkg::rgcd_evt_type evt_out
);
  import rgcd_pkg::*;

  logic         gap_d_reg;
  logic         frame_reg;
  logic         first_reg;
  logic [6:0]   ivl_reg;
  logic [6:0]   wid_reg;
  logic         rise;
  logic         fall;
  rgcd_evt_type evt_reg;

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  assign rise    = gap_in & ~gap_d_reg;
  assign fall    = ~gap_in & gap_d_reg;
  assign evt_out = evt_reg;

  // previous gap level
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      gap_d_reg <= 1'b0;
    end else begin
      gap_d_reg <= gap_in;
    end
  end

  // ----------------------------------------
  // saturating interval and width counters
  // ----------------------------------------
  // counters restart at each gap and saturate, so a stuck field cannot wrap them
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !arm_in) begin
      frame_reg <= 1'b0;
      first_reg <= 1'b0;
      ivl_reg   <= 7'h00;
      wid_reg   <= 7'h00;
    end else if (rise) begin
      ivl_reg <= 7'h01;
      wid_reg <= 7'h01;
      if (!frame_reg) begin
        frame_reg <= 1'b1;
        first_reg <= 1'b1;
      end
    end else begin
      if (ivl_reg != EOT_FC) ivl_reg <= ivl_reg + 7'h01;
      if (gap_in && wid_reg != CNT_SAT) wid_reg <= wid_reg + 7'h01;
      if (fall) first_reg <= 1'b0;
      if (frame_reg && !gap_in && ivl_reg == EOT_FC) frame_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // classification
  // ----------------------------------------
  // interval judged at the next gap, width judged at gap end
  always_ff @(posedge clk_in) begin
    evt_reg <= '0;
    if (rst_n_in && arm_in) begin
      evt_reg.start <= rise & ~frame_reg;
      if (rise && frame_reg) begin
        if (in_win(ivl_reg, D0_MIN, D0_MAX)) begin
          evt_reg.bit_ok <= 1'b1;
        end else if (in_win(ivl_reg, D1_MIN, D1_MAX)) begin
          evt_reg.bit_ok  <= 1'b1;
          evt_reg.bit_val <= 1'b1;
        end else begin
          evt_reg.err <= 1'b1;
        end
      end
      if (fall && frame_reg) begin
        if (first_reg ? !in_win(wid_reg, SGAP_MIN, SGAP_MAX)
                      : !in_win(wid_reg, WGAP_MIN, WGAP_MAX)) begin
          evt_reg.err <= 1'b1;
        end
      end
      evt_reg.eot <= frame_reg & ~gap_in & (ivl_reg == EOT_FC);
    end
  end

endmodule

// [rgcd_properties.sv]
`timescale 1ns/100ps
module rgcd_properties #(
  parameter int PROG_CYCLES = rgcd_pkg::PROG_FC
) (
  // clock and reset
  input wire logic                    SYS_CLK_IN,
  input wire logic                    RST_N_IN,
  // watched ports
  input wire logic                    WB_CYC_IN,
  input wire logic                    WB_STB_IN,
  input wire logic                    WB_ACK_OUT,
  input wire rgcd_pkg::rgcd_prog_type PROG_OUT,
  input wire logic                    MOD_EN_OUT,
  input wire logic                    TEST_STB_OUT,
  input wire logic                    RESET_CMD_OUT,
  input wire logic                    WRITE_ERR_OUT
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  int prog_cnt_reg;
  // length of the current programming burst
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN || !PROG_OUT.en) prog_cnt_reg <= 0;
    else prog_cnt_reg <= prog_cnt_reg + 1;
  end
  sequence req_s; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT; endsequence
  sequence prog_end_s; PROG_OUT.en ##1 !PROG_OUT.en; endsequence
  ack_req_a: assert property (req_s |=> WB_ACK_OUT) else $error("no ack");
  ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("long ack");
  ack_idle_a: assert property (!(WB_CYC_IN && WB_STB_IN) |=> !WB_ACK_OUT)
    else $error("stray ack");
  reset_pulse_a: assert property (RESET_CMD_OUT |=> !RESET_CMD_OUT)
    else $error("long reset pulse");
  error_pulse_a: assert property (WRITE_ERR_OUT |=> !WRITE_ERR_OUT)
    else $error("long error pulse");
  test_pulse_a: assert property (TEST_STB_OUT |=> !TEST_STB_OUT)
    else $error("long test strobe");
  prog_len_a: assert property (prog_end_s |-> $past(prog_cnt_reg) == PROG_CYCLES - 1)
    else $error("bad programming length");
  prog_hold_a: assert property (PROG_OUT.en |=> !PROG_OUT.en || $stable(PROG_OUT))
    else $error("programming fields moved");
  prog_quiet_a: assert property ($rose(PROG_OUT.en) |-> !MOD_EN_OUT)
    else $error("modulating while programming");
endmodule
bind rgcd_cmd_decoder rgcd_properties #(.PROG_CYCLES(PROG_CYCLES)) u_rgcd_properties (.*);

// [rgcd_reader_model.sv]
`timescale 1ns/100ps
module rgcd_reader_model (
  // clock
  input  wire logic clk_in,
  // field gap, high while the field is off
  output logic      gap_out
);
  // ----------------------------------------
  // gapped field source
  // ----------------------------------------
  initial gap_out = 1'b0;
  // one gap of w clocks, next gap ivl clocks after this one starts
  task automatic gap(input int w, input int ivl);
    gap_out <= 1'b1;
    repeat (w) @(posedge clk_in);
    gap_out <= 1'b0;
    repeat (ivl - w) @(posedge clk_in);
  endtask
  // start gap wider, msb first; bad makes the first interval fit no bit
  task automatic send(input logic [69:0] b, input int n, input bit bad);
    @(posedge clk_in);
    for (int i = n - 1; i >= 0; i--) begin
      gap(i == n - 1 ? 20 : 10, (bad && i == n - 1) ? 40 : (b[i] ? 54 : 24));
    end
    gap(10, 74);
  endtask
endmodule

// [tb_rfid_gap_command_decoder.sv]
`timescale 1ns/100ps
module tb_rfid_gap_command_decoder;
  import rgcd_pkg::*;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  logic clk = 1'b0, rst_n, cyc, stb, we, prog_ok, gap, ack, tst, mod, rcmd, werr;
  logic [7:0]    adr;
  logic [3:0]    sel;
  logic [31:0]   dat, rdat, rnd;
  logic [1:0]    seen;
  rgcd_prog_type prog;
  rgcd_rd_type   rd;
  logic [31:0]   exp_q[$];
  int            err_count = 0, tests_run = 0;
  always #20 clk = ~clk;
  rgcd_cmd_decoder #(.PROG_CYCLES(20)) u_rgcd_cmd_decoder (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .GAP_IN(gap), .PROG_OK_IN(prog_ok), .PROG_OUT(prog), .TEST_STB_OUT(tst),
    .MOD_EN_OUT(mod), .RD_OUT(rd), .RESET_CMD_OUT(rcmd), .WRITE_ERR_OUT(werr));
  rgcd_reader_model u_rgcd_reader_model (.clk_in(clk), .gap_out(gap));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo(input int i, input int lim);
    if (i >= lim) begin
      err_count++;
      test_done;
    end
  endtask
  // single classic cycle, held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
    for (i = 0; i < 50 && ack !== 1'b1; i++) @(posedge clk);
    tmo(i, 50);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic wait_en(input logic v);
    int i;
    for (i = 0; i < 400 && prog.en !== v; i++) @(posedge clk);
    tmo(i, 400);
  endtask
  // read data and event pulses watched apart from the driver
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) chk(rdat, exp_q.pop_front());
    if (werr === 1'b1) seen[1] <= 1'b1;
    if (rcmd === 1'b1) seen[0] <= 1'b1;
  end
  initial begin
    {cyc, stb, we, adr, sel, dat, rst_n, prog_ok, seen} = '0;
    rnd = 32'h42061186;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    prog_ok <= 1'b1;
    repeat (200) @(posedge clk);
    rnd = lfsr(rnd);
    rdx(REG_CFG, CFG_RST);
    wb(1'b1, REG_PWD, rnd);
    rdx(REG_PWD, rnd);
    rdx(8'h10, 32'h0);
    u_rgcd_reader_model.send(70'h3, 2, 1'b0);
    repeat (8) @(posedge clk);
    chk(32'(rd.page), 32'h1);
    rnd = lfsr(rnd);
    u_rgcd_reader_model.send(70'({2'b10, 1'b0, rnd, 3'h3}), 38, 1'b0);
    wait_en(1'b1);
    chk(32'({prog.page, prog.lock, prog.addr}), 32'h3);
    chk(prog.data, rnd);
    wait_en(1'b0);
    repeat (3) @(posedge clk);
    chk(32'({rd.block_mode, rd.block}), 32'hB);
    u_rgcd_reader_model.send(70'({2'b11, 1'b0, 3'h5}), 6, 1'b0);
    repeat (8) @(posedge clk);
    chk(32'(rd), 32'h1D);
    u_rgcd_reader_model.send(70'h5, 3, 1'b0);
    repeat (8) @(posedge clk);
    chk(32'({rd.block_mode, rd.page, prog.en}), 32'h2);
    u_rgcd_reader_model.send(70'h2, 2, 1'b1);
    repeat (8) @(posedge clk);
    chk(32'({seen[1], rd.page}), 32'h3);
    u_rgcd_reader_model.send(70'({2'b01, 1'b0, rnd, 3'h1}), 38, 1'b0);
    chk(32'({prog.page, prog.addr}), 32'h9);
    wb(1'b1, REG_CFG, 32'h0000_001E);
    wb(1'b1, REG_PWD, rnd);
    u_rgcd_reader_model.send(70'h0, 2, 1'b0);
    repeat (8) @(posedge clk);
    chk(32'({seen[0], mod}), 32'h2);
    repeat (200) @(posedge clk);
    rdx(REG_STATUS, 32'h0002_0153);
    chk(32'(mod), 32'h0);
    u_rgcd_reader_model.send(70'({2'b10, rnd}), 34, 1'b0);
    repeat (8) @(posedge clk);
    chk(32'(mod), 32'h1);
    u_rgcd_reader_model.send(70'({2'b10, ~rnd, 1'b0, 32'h0, 3'h2}), 70, 1'b0);
    repeat (8) @(posedge clk);
    chk(32'(mod), 32'h0);
    chk(prog.data, rnd);
    prog_ok <= 1'b0;
    u_rgcd_reader_model.send(70'({2'b11, rnd, 1'b1, ~rnd, 3'h6}), 70, 1'b0);
    wait_en(1'b1);
    chk(32'({prog.page, prog.lock, prog.addr}), 32'h1E);
    chk(prog.data, ~rnd);
    wait_en(1'b0);
    repeat (3) @(posedge clk);
    chk(32'({rd.block_mode, mod}), 32'h0);
    test_done;
  end
endmodule
